// [core/cpi_params.svh]
`ifndef CPI_PARAMS_SVH
`define CPI_PARAMS_SVH

// ==========================================================
// Register addresses
`define CPI_ADDR_CONTROL_ZERO 8'hC8
`define CPI_ADDR_CONTROL_ONE 8'hF9
`define CPI_ADDR_FLAGS 8'hE9
`define CPI_ADDR_ENABLES 8'hC9
`define CPI_ADDR_ENCODE 8'hDE

// ==========================================================
// Field positions
`define CPI_BIT_LATCH_TRIGGER 7
`define CPI_BIT_LOOP_START 7
`define CPI_BIT_MODE_HIGH 1
`define CPI_BIT_MODE_LOW 0
`define CPI_DIV_MSB 3
`define CPI_BIT_OVERFLOW 7
`define CPI_BIT_RESERVED 2
`define CPI_BIT_CAPTURE_A 0
`define CPI_BIT_CAPTURE_B 1
`define CPI_BIT_COMPARE_A 3
`define CPI_BIT_COMPARE_B 4
`define CPI_BIT_COMPARE_C 5
`define CPI_BIT_COMPARE_D 6

// ==========================================================
// Reset values and constants
`define CPI_RST_BYTE 8'h00
`define CPI_RST_DIV 4'h0
`define CPI_RST_MODE 2'h0
`define CPI_SYNC_WIDTH 8
`define CPI_LOOP_MULT 32
`define CPI_FLAG_MASK 8'hFB

`endif

// [core/cpi_pkg.sv]
package cpi_pkg;
  typedef logic [7:0] cpi_byte_t;
  typedef logic [2:0] cpi_code_t;
  typedef enum logic [1:0]
  {
    CPI_LT_IDLE = 2'b01,
    CPI_LT_PEND = 2'b10
  } cpi_latch_state_t;
endpackage : cpi_pkg

// [core/cpi_sync.sv]
`timescale 1ns/1ps
`include "cpi_params.svh"

module cpi_sync
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`CPI_SYNC_WIDTH-1:0] async_i,
  output logic [`CPI_SYNC_WIDTH-1:0] sync_o
);
  wire [`CPI_SYNC_WIDTH-1:0] stage_two_w;

  // ==========================================================
  // Two stages; first stage feeds only the second
  // Per-bit flops keep each process owning whole variables
  genvar g;
  generate
    for (g = 0; g < `CPI_SYNC_WIDTH; g = g + 1)
    begin : g_bit
      logic one_r;
      logic two_r;
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          one_r <= 1'b0;
          two_r <= 1'b0;
        end
        else
        begin
          one_r <= async_i[g];
          two_r <= one_r;
        end
      end
      assign stage_two_w[g] = two_r;
    end
  endgenerate

  assign sync_o = stage_two_w;
endmodule : cpi_sync

// [core/cpi_unit.sv]
// Summary of operation
// - Loop multiplies 0.5-1 MHz reference by 32
// - Reference is clock over divider plus one
// - Timer clock then lies 16 to 32 MHz
// - Top value sets period up to 16 bits
// - Basic mode trigger latches now, reads zero
// - PWM trigger waits overflow, reads one pending
// - Same trigger latches compare shadow registers too
// - Start bit reads one only after lock
// - Timer events are synchronised into cpu clock
// - Seven sources share one interrupt vector
// - Each flag gated by its enable first
// - Fixed priority overflow down to compare D
// - Three bit code reports highest pending source
// - Flags set by event, cleared writing zero
`timescale 1ns/1ps
`include "cpi_params.svh"

module cpi_unit
  import cpi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire cpi_pkg::cpi_byte_t sfr_wdata_i,
  output cpi_pkg::cpi_byte_t sfr_rdata_o,
  input wire logic [`CPI_SYNC_WIDTH-1:0] event_toggle_i,
  input wire logic loop_locked_i,
  output logic loop_start_lock_o,
  output logic loop_ref_tick_o,
  output logic [1:0] timer_mode_o,
  output logic shadow_load_o,
  output logic shadow_pending_o,
  output logic interrupt_o
);
  import cpi_pkg::*;

  // ==========================================================
  // Priority encoder
  function automatic cpi_code_t encode_source(input cpi_byte_t pend);
    cpi_code_t code;
    code = 3'h0;
    if (pend[`CPI_BIT_OVERFLOW]) code = 3'h7;
    else if (pend[`CPI_BIT_CAPTURE_A]) code = 3'h6;
    else if (pend[`CPI_BIT_CAPTURE_B]) code = 3'h5;
    else if (pend[`CPI_BIT_COMPARE_A]) code = 3'h4;
    else if (pend[`CPI_BIT_COMPARE_B]) code = 3'h3;
    else if (pend[`CPI_BIT_COMPARE_C]) code = 3'h2;
    else if (pend[`CPI_BIT_COMPARE_D]) code = 3'h1;
    return code;
  endfunction : encode_source

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : hit

  // ==========================================================
  // Crossing from the timer domain
  logic [`CPI_SYNC_WIDTH-1:0] raw_in;
  logic [`CPI_SYNC_WIDTH-1:0] synced;
  logic [`CPI_SYNC_WIDTH-1:0] seen_r;
  logic [`CPI_SYNC_WIDTH-1:0] seen_nxt;
  cpi_byte_t event_pulse;
  logic lock_seen;

  // Reserved flag slot carries the lock level through the same stages
  always_comb
  begin
    raw_in = event_toggle_i;
    raw_in[`CPI_BIT_RESERVED] = loop_locked_i;
  end

  cpi_sync u_sync
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(raw_in),
    .sync_o(synced)
  );

  always_comb
  begin
    seen_nxt = synced;
    event_pulse = (synced ^ seen_r) & `CPI_FLAG_MASK;
    lock_seen = synced[`CPI_BIT_RESERVED];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      seen_r <= `CPI_RST_BYTE;
    else
      seen_r <= seen_nxt;
  end

  // ==========================================================
  // Control registers
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_flags;
  logic wr_enables;
  logic loop_start_r;
  logic loop_start_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [`CPI_DIV_MSB:0] div_r;
  logic [`CPI_DIV_MSB:0] div_nxt;
  cpi_byte_t enable_r;
  cpi_byte_t enable_nxt;

  always_comb
  begin
    wr_ctl0 = sfr_wr_i && hit(sfr_addr_i, `CPI_ADDR_CONTROL_ZERO);
    wr_ctl1 = sfr_wr_i && hit(sfr_addr_i, `CPI_ADDR_CONTROL_ONE);
    wr_flags = sfr_wr_i && hit(sfr_addr_i, `CPI_ADDR_FLAGS);
    wr_enables = sfr_wr_i && hit(sfr_addr_i, `CPI_ADDR_ENABLES);
    loop_start_nxt = loop_start_r;
    mode_nxt = mode_r;
    div_nxt = div_r;
    enable_nxt = enable_r;
    if (wr_ctl0)
    begin
      loop_start_nxt = sfr_wdata_i[`CPI_BIT_LOOP_START];
      mode_nxt = sfr_wdata_i[`CPI_BIT_MODE_HIGH:`CPI_BIT_MODE_LOW];
    end
    if (wr_ctl1)
      div_nxt = sfr_wdata_i[`CPI_DIV_MSB:0];
    if (wr_enables)
      enable_nxt = sfr_wdata_i & `CPI_FLAG_MASK;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      loop_start_r <= 1'b0;
      mode_r <= `CPI_RST_MODE;
      div_r <= `CPI_RST_DIV;
      enable_r <= `CPI_RST_BYTE;
    end
    else
    begin
      loop_start_r <= loop_start_nxt;
      mode_r <= mode_nxt;
      div_r <= div_nxt;
      enable_r <= enable_nxt;
    end
  end

  // ==========================================================
  // Reference divider
  // Multiplier itself is analog; only its reference is made here
  logic [`CPI_DIV_MSB:0] ref_cnt_r;
  logic [`CPI_DIV_MSB:0] ref_cnt_nxt;
  logic ref_tick_r;
  logic ref_tick_nxt;

  always_comb
  begin
    ref_cnt_nxt = ref_cnt_r + 4'h1;
    ref_tick_nxt = 1'b0;
    if (!loop_start_r)
      ref_cnt_nxt = `CPI_RST_DIV;
    else if (ref_cnt_r >= div_r)
    begin
      ref_cnt_nxt = `CPI_RST_DIV;
      ref_tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_cnt_r <= `CPI_RST_DIV;
      ref_tick_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= ref_cnt_nxt;
      ref_tick_r <= ref_tick_nxt;
    end
  end

  // ==========================================================
  // Shadow latch trigger
  cpi_latch_state_t latch_r;
  cpi_latch_state_t latch_nxt;
  logic load_r;
  logic load_nxt;
  logic trigger_wr;
  logic pwm_mode;

  always_comb
  begin
    trigger_wr = wr_ctl1 && sfr_wdata_i[`CPI_BIT_LATCH_TRIGGER];
    pwm_mode = mode_r[`CPI_BIT_MODE_HIGH];
    latch_nxt = latch_r;
    load_nxt = 1'b0;
    case (latch_r)
      CPI_LT_IDLE:
      begin
        if (trigger_wr && !pwm_mode)
          load_nxt = 1'b1;
        else if (trigger_wr)
          latch_nxt = CPI_LT_PEND;
      end
      CPI_LT_PEND:
      begin
        if (event_pulse[`CPI_BIT_OVERFLOW])
        begin
          load_nxt = 1'b1;
          latch_nxt = CPI_LT_IDLE;
        end
      end
      default:
        latch_nxt = CPI_LT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      latch_r <= CPI_LT_IDLE;
      load_r <= 1'b0;
    end
    else
    begin
      latch_r <= latch_nxt;
      load_r <= load_nxt;
    end
  end

  // ==========================================================
  // Flags, encoder and read data
  cpi_byte_t flag_r;
  cpi_byte_t flag_nxt;
  cpi_byte_t pending;
  cpi_byte_t rdata_r;
  cpi_byte_t rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_flags)
      flag_nxt = flag_r & sfr_wdata_i;
    flag_nxt = (flag_nxt | event_pulse) & `CPI_FLAG_MASK;
    pending = flag_r & enable_r;
    irq_nxt = |(flag_nxt & enable_nxt);
    rdata_nxt = `CPI_RST_BYTE;
    if (sfr_rd_i)
    begin
      if (hit(sfr_addr_i, `CPI_ADDR_CONTROL_ZERO))
      begin
        rdata_nxt[`CPI_BIT_LOOP_START] = loop_start_r && lock_seen;
        rdata_nxt[`CPI_BIT_MODE_HIGH:`CPI_BIT_MODE_LOW] = mode_r;
      end
      else if (hit(sfr_addr_i, `CPI_ADDR_CONTROL_ONE))
      begin
        rdata_nxt[`CPI_DIV_MSB:0] = div_r;
        rdata_nxt[`CPI_BIT_LATCH_TRIGGER] = (latch_r == CPI_LT_PEND);
      end
      else if (hit(sfr_addr_i, `CPI_ADDR_FLAGS))
        rdata_nxt = flag_r;
      else if (hit(sfr_addr_i, `CPI_ADDR_ENABLES))
        rdata_nxt = enable_r;
      else if (hit(sfr_addr_i, `CPI_ADDR_ENCODE))
        rdata_nxt[2:0] = encode_source(pending);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flag_r <= `CPI_RST_BYTE;
      rdata_r <= `CPI_RST_BYTE;
      irq_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign sfr_rdata_o = rdata_r;
  assign loop_start_lock_o = loop_start_r;
  assign loop_ref_tick_o = ref_tick_r;
  assign timer_mode_o = mode_r;
  // Load strobe moves the 16-bit top value pair with the compares
  assign shadow_load_o = load_r;
  // One-hot bit of the pending state, straight from its flop
  assign shadow_pending_o = latch_r[1];
  assign interrupt_o = irq_r;
endmodule : cpi_unit

// [tb/cpi_unit_checker.sv]
`timescale 1ns/1ps
`include "cpi_params.svh"
// ==========================================================
// Port checker
module cpi_unit_checker
  import cpi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire cpi_pkg::cpi_byte_t sfr_wdata_i,
  input wire cpi_pkg::cpi_byte_t sfr_rdata_o,
  input wire logic loop_locked_i,
  input wire logic loop_start_lock_o,
  input wire logic loop_ref_tick_o,
  input wire logic [1:0] timer_mode_o,
  input wire logic shadow_load_o,
  input wire logic shadow_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_trig;
    sfr_wr_i && sfr_addr_i == `CPI_ADDR_CONTROL_ONE && sfr_wdata_i[7] && !shadow_pending_o;
  endsequence
  sequence s_rd(a);
    sfr_rd_i && sfr_addr_i == a;
  endsequence
  a_basic_latch_now: assert property (s_trig ##0 !timer_mode_o[1] |=> shadow_load_o)
    else $error("basic trigger gave no load");
  a_pwm_trig_pending: assert property (s_trig ##0 timer_mode_o[1] |=> shadow_pending_o)
    else $error("pwm trigger not pending");
  a_pend_ends_load: assert property ($fell(shadow_pending_o) |-> shadow_load_o)
    else $error("pending ended without load");
  a_rdata_idle_zero: assert property (!$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00)
    else $error("read data without read");
  a_trig_read_back: assert property (s_rd(`CPI_ADDR_CONTROL_ONE) |=>
    sfr_rdata_o[7] == $past(shadow_pending_o) && sfr_rdata_o[6:4] == 3'h0)
    else $error("trigger bit read wrong");
  a_encode_top_zero: assert property (s_rd(`CPI_ADDR_ENCODE) |=> sfr_rdata_o[7:3] == 5'h00)
    else $error("encode upper bits set");
  a_flag_gap_zero: assert property (s_rd(`CPI_ADDR_FLAGS) |=> !sfr_rdata_o[2])
    else $error("reserved flag set");
  a_lock_read_gate: assert property (s_rd(`CPI_ADDR_CONTROL_ZERO)
    ##0 (!loop_start_lock_o || !$past(loop_locked_i, 2)) |=> !sfr_rdata_o[7])
    else $error("start bit read one before lock");
  a_tick_needs_start: assert property ((!loop_start_lock_o) [*3] |-> !loop_ref_tick_o)
    else $error("tick while stopped");
endmodule : cpi_unit_checker

bind cpi_unit cpi_unit_checker chk_u (.clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_wdata_i, .sfr_rdata_o, .loop_locked_i, .loop_start_lock_o, .loop_ref_tick_o,
  .timer_mode_o, .shadow_load_o, .shadow_pending_o);

// [tb/cpi_timer_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Timer side: event toggles and loop lock
module cpi_timer_model
#(
  parameter int LOCK_CYC = 20
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] fire_i,
  input wire logic start_i,
  output logic [7:0] event_toggle_o,
  output logic locked_o
);
  int cnt;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      event_toggle_o <= 8'h00;
      cnt <= 0;
    end
    else
    begin
      event_toggle_o <= event_toggle_o ^ fire_i;
      cnt <= start_i ? cnt + int'(cnt < LOCK_CYC) : 0;
    end
  end
  // Lock drops at once on stop; no hysteresis
  assign locked_o = (cnt == LOCK_CYC);
endmodule : cpi_timer_model

// [tb/test_capture_unit_pll_and_irq_priority.sv]
`timescale 1ns/1ps
`include "cpi_params.svh"
module test_capture_unit_pll_and_irq_priority;
  import cpi_pkg::*;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 0;
  logic sfr_rd_i = 0;
  cpi_byte_t sfr_wdata_i = 8'h00;
  cpi_byte_t sfr_rdata_o;
  cpi_byte_t got;
  logic [7:0] fire = 8'h00;
  logic [7:0] event_toggle_i;
  logic [1:0] timer_mode_o;
  logic loop_locked_i, loop_start_lock_o, loop_ref_tick_o;
  logic shadow_load_o, shadow_pending_o, interrupt_o;
  int n_fail = 0;
  int n_tests = 0;
  int k;
  int cnt;
  int dv[3] = '{0, 3, 15};
  logic [7:0] ad[5] = '{8'hC8, 8'hF9, 8'hE9, 8'hC9, 8'hDE};
  // Rows: enables, events, expected code
  logic [7:0] tab[10][3] = '{'{8'hFF, 8'h80, 8'h07}, '{8'hFF, 8'h01, 8'h06},
    '{8'hFF, 8'h02, 8'h05}, '{8'hFF, 8'h08, 8'h04}, '{8'hFF, 8'h10, 8'h03},
    '{8'hFF, 8'h20, 8'h02}, '{8'hFF, 8'h40, 8'h01}, '{8'h7F, 8'hFF, 8'h06},
    '{8'h00, 8'hFF, 8'h00}, '{8'h78, 8'h7B, 8'h04}};
  always #2.5 clk_i = ~clk_i;
  cpi_unit dut_u (.clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .event_toggle_i, .loop_locked_i, .loop_start_lock_o, .loop_ref_tick_o,
    .timer_mode_o, .shadow_load_o, .shadow_pending_o, .interrupt_o);
  cpi_timer_model part_u (.clk_i, .reset_n_i, .fire_i(fire), .start_i(loop_start_lock_o),
    .event_toggle_o(event_toggle_i), .locked_o(loop_locked_i));
  // ==========================================================
  // Bus tasks; one idle cycle first so no strobe is set twice in a step
  task automatic chk(input cpi_byte_t g, input cpi_byte_t e);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input cpi_byte_t d);
    @(posedge clk_i);
    #1 sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    @(posedge clk_i);
    #1 sfr_wr_i = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    #1 sfr_addr_i = a;
    sfr_rd_i = 1;
    @(posedge clk_i);
    #1 sfr_rd_i = 0;
    got = sfr_rdata_o;
  endtask : rd
  task automatic rc(input logic [7:0] a, input cpi_byte_t e);
    rd(a);
    chk(got, e);
  endtask : rc
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    #1 fire = m;
    @(posedge clk_i);
    #1 fire = 8'h00;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : pulse
  task automatic conclude();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // Sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1;
    for (k = 0; k < 10; k++)
    begin
      wr(`CPI_ADDR_ENABLES, tab[k][0]);
      pulse(tab[k][1]);
      rc(`CPI_ADDR_FLAGS, tab[k][1] & `CPI_FLAG_MASK);
      rc(`CPI_ADDR_ENCODE, tab[k][2]);
      chk({7'h00, interrupt_o}, {7'h00, |tab[k][2]});
      wr(`CPI_ADDR_FLAGS, 8'h00);
      rc(`CPI_ADDR_ENCODE, 8'h00);
    end
    $display("priority table done");
    wr(`CPI_ADDR_ENABLES, 8'hFF);
    pulse(8'h81);
    wr(`CPI_ADDR_FLAGS, 8'h80);
    rc(`CPI_ADDR_FLAGS, 8'h80);
    rc(`CPI_ADDR_ENCODE, 8'h07);
    wr(`CPI_ADDR_FLAGS, 8'h7F);
    rc(`CPI_ADDR_ENCODE, 8'h00);
    wr(8'h55, 8'hFF);
    rc(8'h55, 8'h00);
    $display("flag clear done");
    wr(`CPI_ADDR_CONTROL_ZERO, 8'h80);
    rc(`CPI_ADDR_CONTROL_ZERO, 8'h00);
    for (k = 0; k < 50 && got !== 8'h80; k++)
      rd(`CPI_ADDR_CONTROL_ZERO);
    chk(got, 8'h80);
    foreach (dv[i])
    begin
      wr(`CPI_ADDR_CONTROL_ONE, 8'(dv[i]));
      repeat (20) @(posedge clk_i);
      cnt = 0;
      repeat (64)
      begin
        @(posedge clk_i);
        #1 cnt += int'(loop_ref_tick_o === 1'b1);
      end
      chk(8'(cnt), 8'(64 / (dv[i] + 1)));
    end
    $display("loop start done");
    wr(`CPI_ADDR_CONTROL_ONE, 8'h80);
    chk({7'h00, shadow_load_o}, 8'h01);
    rc(`CPI_ADDR_CONTROL_ONE, 8'h00);
    wr(`CPI_ADDR_CONTROL_ZERO, 8'h82);
    chk({loop_start_lock_o, 5'h00, timer_mode_o}, 8'h82);
    wr(`CPI_ADDR_CONTROL_ONE, 8'h83);
    rc(`CPI_ADDR_CONTROL_ONE, 8'h83);
    wr(`CPI_ADDR_CONTROL_ONE, 8'h83);
    chk({7'h00, shadow_pending_o}, 8'h01);
    @(posedge clk_i);
    #1 fire = 8'h80;
    @(posedge clk_i);
    #1 fire = 8'h00;
    for (k = 0; k < 10 && shadow_load_o !== 1'b1; k++)
      @(posedge clk_i) #1;
    chk({7'h00, shadow_load_o}, 8'h01);
    rc(`CPI_ADDR_CONTROL_ONE, 8'h03);
    $display("latch trigger done");
    reset_n_i = 0;
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1;
    chk({loop_start_lock_o, loop_ref_tick_o, timer_mode_o, shadow_load_o, shadow_pending_o,
      interrupt_o, 1'b0}, 8'h00);
    foreach (ad[i])
      rc(ad[i], 8'h00);
    $display("reset values done");
    conclude();
  end
  initial
  begin
    #50000;
    n_fail++;
    conclude();
  end
endmodule : test_capture_unit_pll_and_irq_priority
